// [verilog/fpg_guard_map.svh]
// Address, lock, command and timing constants of the flash self-program access guard.
`ifndef FPG_GUARD_MAP_SVH
`define FPG_GUARD_MAP_SVH
//
// Behaviour
// R1: Concurrent-region programming keeps stalling-region reads flowing.
// R2: Stalling-region programming stalls processor whole operation.
// R3: Blocked concurrent region never returns valid data.
// R4: Region busy flag set while region blocked.
// R5: Region stays blocked until software clears flag.
// R6: Software keeps accesses away from region during programming.
// R7: Boot-loader region lies inside stalling region.
// R8: Stall decision uses programmed page address region.
// R9: Two lock pairs, set by software or programmer; the code sets them only by the software lock set command.
// R10: Lock bits return unprogrammed only by chip erase; the code also frees both pairs at reset.
// R11: General lock modes never gate self-programming.
// R12: App lock 11: writes and reads allowed.
// R13: App lock 10: writes refused, reads allowed.
// R14: App lock 00: no writes, no boot reads.
// R15: App lock 01: writes allowed, no boot reads.
// R16: App modes 3,4: suppress interrupts in application.
// R17: Boot lock 11: writes and reads allowed.
// R18: Boot lock 10: writes refused, reads allowed.
// R19: Boot lock 00: no writes, no app reads.
// R20: Boot lock 01: writes allowed, no app reads.
// R21: Boot modes 3,4: suppress interrupts in boot region.
// R22: Store-program from application region is ignored.
// R23: Busy flag set when concurrent programming starts.
// R24: Busy cleared by re-enable or page-buffer load.
// R25: Boundary and boot size are parameters.
// R26: Refused accesses change nothing, flag nothing.
//
`define FPG_AW 15
`define FPG_STALL_BASE 15'h7000
`define FPG_BOOT_MAX 15'h1000
`define FPG_BOOT_DFLT 15'h1000
`define FPG_RD_BLOCKED 16'hffff
`define FPG_OP_BUSY_NS 4000
`define FPG_OP_CYC ((`FPG_OP_BUSY_NS + 4) / 5)
`define FPG_LOCK_FREE 2'h3
`define FPG_REG_CTRL 4'h0
`define FPG_REG_LOCK 4'h1
`define FPG_REG_STAT 4'h2
`define FPG_CMD_LOAD 3'h0
`define FPG_CMD_ERASE 3'h1
`define FPG_CMD_WRITE 3'h2
`define FPG_CMD_REEN 3'h3
`define FPG_CMD_LOCKSET 3'h4
`define FPG_CMD_CHIPERASE 3'h5
`endif

// [verilog/fpg_guard_pkg.sv]
// Types shared by the flash self-program access guard.
package fpg_guard_pkg;
    typedef enum logic [1:0] {
        FPG_IDLE = 2'h0,
        FPG_BUSY = 2'h1,
        FPG_DONE = 2'h3
    } fpg_state_e;

    typedef struct packed {
        logic [1:0] app_lock;
        logic [1:0] boot_lock;
    } fpg_locks_s;

    typedef struct packed {
        fpg_state_e st;
        logic [15:0] cnt;
        logic stall_op;
        logic busy_flag;
        fpg_locks_s locks;
        logic [14:0] boot_size;
        logic ivec_boot;
        logic [15:0] rdata;
        logic rvalid;
        logic stall;
        logic irq_mask;
        logic prog_pulse;
        logic erase_pulse;
        logic [14:0] prog_addr;
        logic [15:0] bus_rdata;
    } fpg_state_s;
endpackage : fpg_guard_pkg

// [verilog/fpg_guard.sv]
// Flash self-program access guard: region blocking, stall and boot lock checks.
`timescale 1ns/10ps
`include "fpg_guard_map.svh"

module fpg_guard
    import fpg_guard_pkg::*;
(
    input wire logic i_sys_clk, // System clock, 200 MHz.
    input wire logic i_resetn, // Synchronous reset, active low.
    input wire logic i_sp_req, // Store-program request pulse from core.
    input wire logic [2:0] i_sp_cmd, // Store-program command code.
    input wire logic [14:0] i_sp_addr, // Page word address of the operation.
    input wire logic [3:0] i_sp_lockdata, // Lock value, zeros program bits.
    input wire logic [14:0] i_pc, // Address of the executing instruction.
    input wire logic i_rd_req, // Fetch or program-memory load request.
    input wire logic i_rd_is_load, // Request is a program-memory load.
    input wire logic [14:0] i_rd_addr, // Read word address.
    input wire logic [15:0] i_flash_rdata, // Raw flash array data.
    input wire logic [3:0] i_reg_addr, // Register address.
    input wire logic [15:0] i_reg_wdata, // Register write data.
    input wire logic i_reg_wr, // Register write strobe.
    input wire logic i_reg_rd, // Register read strobe.
    output logic [15:0] o_reg_rdata, // Register read data.
    output logic [15:0] o_rd_data, // Guarded read data.
    output logic o_rd_valid, // Read data valid.
    output logic o_cpu_stall, // Processor halt.
    output logic o_irq_suppress, // Interrupt suppression.
    output logic o_flash_prog, // Flash program pulse.
    output logic o_flash_erase, // Flash erase pulse.
    output logic [14:0] o_flash_addr, // Flash operation address.
    output logic o_region_busy_flag // Concurrent-read region blocked.
);
    fpg_state_s s_r;
    fpg_state_s s_nxt;

    logic sp_in_boot;
    logic pc_in_boot;
    logic rd_in_boot;
    logic tgt_in_boot;
    logic tgt_stalling;
    logic rd_stalling;
    logic wr_ok;
    logic rd_ok;
    logic [14:0] boot_base;
    logic [1:0] pair;

    // ************************************************************
    // Region decode.
    // ************************************************************
    always_comb begin
        boot_base = 15'h7fff - s_r.boot_size + 15'h0001; // R7 R25
        if (boot_base < `FPG_STALL_BASE) begin
            boot_base = `FPG_STALL_BASE; // R7
        end
        pc_in_boot = (i_pc >= boot_base);
        sp_in_boot = pc_in_boot;
        rd_in_boot = (i_rd_addr >= boot_base);
        tgt_in_boot = (i_sp_addr >= boot_base);
        tgt_stalling = (i_sp_addr >= `FPG_STALL_BASE); // R8 R25
        rd_stalling = (i_rd_addr >= `FPG_STALL_BASE);
        // Write permission: upper bit don't care, lower bit 0 refuses.
        pair = tgt_in_boot ? s_r.locks.boot_lock : s_r.locks.app_lock;
        wr_ok = pair[0]; // R12 R13 R14 R15 R17 R18 R19 R20 R11
        // Cross-region loads are refused when the upper lock bit is programmed.
        rd_ok = 1'b1;
        if (i_rd_is_load && pc_in_boot && !rd_in_boot && !s_r.locks.app_lock[1]) begin
            rd_ok = 1'b0; // R14 R15
        end
        if (i_rd_is_load && !pc_in_boot && rd_in_boot && !s_r.locks.boot_lock[1]) begin
            rd_ok = 1'b0; // R19 R20
        end
    end

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.prog_pulse = 1'b0;
        s_nxt.erase_pulse = 1'b0;
        s_nxt.rvalid = 1'b0;
        s_nxt.rdata = `FPG_RD_BLOCKED;
        s_nxt.bus_rdata = 16'h0000;

        case (s_r.st)
            FPG_IDLE: begin
                // Commands other than chip erase from outside the boot region are dropped silently.
                if (i_sp_req && sp_in_boot) begin // R22
                    case (i_sp_cmd)
                        `FPG_CMD_ERASE, `FPG_CMD_WRITE: begin
                            if (wr_ok) begin // R26
                                s_nxt.prog_pulse = (i_sp_cmd == `FPG_CMD_WRITE);
                                s_nxt.erase_pulse = (i_sp_cmd == `FPG_CMD_ERASE);
                                s_nxt.prog_addr = i_sp_addr;
                                s_nxt.stall_op = tgt_stalling; // R8
                                s_nxt.busy_flag = s_r.busy_flag | ~tgt_stalling; // R23
                                s_nxt.cnt = 16'(`FPG_OP_CYC);
                                s_nxt.st = FPG_BUSY;
                            end
                        end
                        `FPG_CMD_LOAD: begin
                            s_nxt.busy_flag = 1'b0; // R24
                        end
                        `FPG_CMD_REEN: begin
                            s_nxt.busy_flag = 1'b0; // R24 R5
                        end
                        `FPG_CMD_LOCKSET: begin
                            // Software can only program bits (drive to 0).
                            s_nxt.locks.app_lock = s_r.locks.app_lock & i_sp_lockdata[1:0]; // R9
                            s_nxt.locks.boot_lock = s_r.locks.boot_lock & i_sp_lockdata[3:2]; // R9 R10
                        end
                        default: begin
                        end
                    endcase
                end
                // Parallel/serial programming path: chip erase frees both lock pairs.
                if (i_sp_req && i_sp_cmd == `FPG_CMD_CHIPERASE) begin
                    s_nxt.locks.app_lock = `FPG_LOCK_FREE; // R10
                    s_nxt.locks.boot_lock = `FPG_LOCK_FREE; // R10
                end
            end
            FPG_BUSY: begin
                if (s_r.cnt == 16'h0001) begin
                    s_nxt.st = FPG_DONE;
                end
                s_nxt.cnt = s_r.cnt - 16'h0001;
            end
            FPG_DONE: begin
                s_nxt.stall_op = 1'b0;
                s_nxt.st = FPG_IDLE;
            end
            default: begin
                s_nxt.st = FPG_IDLE;
            end
        endcase

        s_nxt.stall = (s_nxt.st == FPG_BUSY) && s_nxt.stall_op; // R2

        // ************************************************************
        // Guarded reads.
        // ************************************************************
        if (i_rd_req) begin
            s_nxt.rvalid = 1'b1;
            if (!rd_stalling && s_r.busy_flag) begin
                s_nxt.rdata = `FPG_RD_BLOCKED; // R3 R5 R6
            end else if (!rd_ok) begin
                s_nxt.rdata = `FPG_RD_BLOCKED; // R26
            end else begin
                s_nxt.rdata = i_flash_rdata; // R1
            end
        end

        s_nxt.irq_mask = 1'b0;
        if (s_r.ivec_boot && !pc_in_boot && !s_r.locks.app_lock[1]) begin
            s_nxt.irq_mask = 1'b1; // R16
        end
        if (!s_r.ivec_boot && pc_in_boot && !s_r.locks.boot_lock[1]) begin
            s_nxt.irq_mask = 1'b1; // R21
        end

        // ************************************************************
        // Register port.
        // ************************************************************
        if (i_reg_wr && i_reg_addr == `FPG_REG_CTRL) begin
            s_nxt.boot_size = (i_reg_wdata[14:0] > `FPG_BOOT_MAX) ? `FPG_BOOT_MAX
                : i_reg_wdata[14:0]; // R7
            s_nxt.ivec_boot = i_reg_wdata[15];
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                `FPG_REG_CTRL: s_nxt.bus_rdata = {s_r.ivec_boot, s_r.boot_size};
                // Boot pair sits above the application pair, as in the lock set data.
                `FPG_REG_LOCK: s_nxt.bus_rdata = {12'h000, s_r.locks.boot_lock,
                    s_r.locks.app_lock}; // R9
                `FPG_REG_STAT: s_nxt.bus_rdata = {13'h0000, s_r.stall_op,
                    (s_r.st != FPG_IDLE), s_r.busy_flag}; // R4
                default: s_nxt.bus_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            s_r <= '0;
            s_r.st <= FPG_IDLE;
            s_r.locks.app_lock <= `FPG_LOCK_FREE;
            s_r.locks.boot_lock <= `FPG_LOCK_FREE;
            s_r.boot_size <= `FPG_BOOT_DFLT;
            s_r.ivec_boot <= 1'b0;
            s_r.rdata <= `FPG_RD_BLOCKED;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_reg_rdata = s_r.bus_rdata;
    assign o_rd_data = s_r.rdata;
    assign o_rd_valid = s_r.rvalid;
    assign o_cpu_stall = s_r.stall;
    assign o_irq_suppress = s_r.irq_mask;
    assign o_flash_prog = s_r.prog_pulse;
    assign o_flash_erase = s_r.erase_pulse;
    assign o_flash_addr = s_r.prog_addr;
    assign o_region_busy_flag = s_r.busy_flag; // R4
endmodule : fpg_guard

// [dv/fpg_guard_monitor.sv]
// Port checker for the flash self-program access guard.
`timescale 1ns/10ps
`include "fpg_guard_map.svh"

module fpg_guard_monitor (
    input wire logic i_sys_clk, // Clock.
    input wire logic i_resetn, // Reset, active low.
    input wire logic i_sp_req, // Store-program request.
    input wire logic [2:0] i_sp_cmd, // Command code.
    input wire logic [14:0] i_pc, // Executing address.
    input wire logic i_rd_req, // Read request.
    input wire logic [14:0] i_rd_addr, // Read address.
    input wire logic [15:0] o_rd_data, // Guarded data.
    input wire logic o_rd_valid, // Data valid.
    input wire logic o_cpu_stall, // Processor halt.
    input wire logic o_flash_prog, // Program pulse.
    input wire logic o_flash_erase, // Erase pulse.
    input wire logic [14:0] o_flash_addr, // Operation address.
    input wire logic o_region_busy_flag // Region blocked.
);
    // ****************************************
    // Stall length counter and assertions
    // ****************************************
    logic [15:0] stall_cnt_r;
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn || !o_cpu_stall) begin
            stall_cnt_r <= 16'h0;
        end else begin
            stall_cnt_r <= stall_cnt_r + 16'h1;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    a_prog_cause: assert property (
        $rose(o_flash_prog) |-> $past(i_sp_req) && $past(i_sp_cmd) == `FPG_CMD_WRITE
            && $past(i_pc) >= `FPG_STALL_BASE) else $error("program pulse without request");
    a_erase_cause: assert property (
        $rose(o_flash_erase) |-> $past(i_sp_req) && $past(i_sp_cmd) == `FPG_CMD_ERASE
            && $past(i_pc) >= `FPG_STALL_BASE) else $error("erase pulse without request");
    a_rd_answer: assert property (o_rd_valid == $past(i_rd_req))
        else $error("read answer not one cycle after request");
    a_rd_blocked: assert property (
        o_rd_valid && $past(o_region_busy_flag) && $past(i_rd_addr) < `FPG_STALL_BASE
            |-> o_rd_data == `FPG_RD_BLOCKED) else $error("blocked region returned data");
    a_stall_len: assert property (
        $fell(o_cpu_stall) |-> stall_cnt_r == 16'(`FPG_OP_CYC)) else $error("stall length wrong");
    a_stall_start: assert property (
        $rose(o_cpu_stall) |-> ($past(o_flash_prog) || $past(o_flash_erase) || o_flash_prog
            || o_flash_erase) && o_flash_addr >= `FPG_STALL_BASE) else $error("stall without op");
    a_busy_set: assert property (
        $rose(o_region_busy_flag) |-> (o_flash_prog || o_flash_erase) && !o_cpu_stall
            && o_flash_addr < `FPG_STALL_BASE) else $error("busy flag raised without op");
    a_busy_clear: assert property (
        $fell(o_region_busy_flag) |-> $past(i_sp_req) && ($past(i_sp_cmd) == `FPG_CMD_REEN
            || $past(i_sp_cmd) == `FPG_CMD_LOAD)) else $error("busy flag dropped on its own");
endmodule : fpg_guard_monitor

bind fpg_guard fpg_guard_monitor u_mon (.i_sys_clk, .i_resetn, .i_sp_req, .i_sp_cmd, .i_pc,
    .i_rd_req, .i_rd_addr, .o_rd_data, .o_rd_valid, .o_cpu_stall, .o_flash_prog,
    .o_flash_erase, .o_flash_addr, .o_region_busy_flag);

// [dv/fpg_flash_model.sv]
// Flash array stand-in that feeds raw read data to the guard.
`timescale 1ns/10ps

module fpg_flash_model (
    input wire logic i_rd_req, // Read request.
    input wire logic [14:0] i_rd_addr, // Read address.
    output logic [15:0] o_rdata // Array data.
);
    // ****************************************
    // Array contents
    // ****************************************
    // Outside a read the word is inverted, so stale data can never pass for a hit.
    assign o_rdata = i_rd_req ? ({1'b0, i_rd_addr} ^ 16'h5a5a) : ~({1'b0, i_rd_addr} ^ 16'h5a5a);
endmodule : fpg_flash_model

// [dv/fpg_guard_tb_top.sv]
// Self-checking bench for the flash self-program access guard.
`timescale 1ns/10ps
`include "fpg_guard_map.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t got %h exp %h", $time, (a), (e)); end end

module fpg_guard_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sp_req = 1'b0, rd_req = 1'b0, ld = 1'b0, rwr = 1'b0, rrd = 1'b0;
    logic [2:0] cmd = 3'h0;
    logic [14:0] sp_a = 15'h0, pc = 15'h7800, rd_a = 15'h0;
    logic [3:0] lk = 4'hf, ra = 4'h0;
    logic [15:0] wd = 16'h0;
    wire logic [15:0] frd, rdat, rgd;
    wire logic rval, stall, irq, prog, ers, busy;
    wire logic [14:0] fa;
    int num_errors = 0;
    int compares = 0;
    // ****************************************
    // Clock, partner and design
    // ****************************************
    initial begin
        forever #2.5 clk = ~clk;
    end
    fpg_flash_model u_flash (.i_rd_req(rd_req), .i_rd_addr(rd_a), .o_rdata(frd));
    fpg_guard dut (.i_sys_clk(clk), .i_resetn(rstn), .i_sp_req(sp_req), .i_sp_cmd(cmd),
        .i_sp_addr(sp_a), .i_sp_lockdata(lk), .i_pc(pc), .i_rd_req(rd_req), .i_rd_is_load(ld),
        .i_rd_addr(rd_a), .i_flash_rdata(frd), .i_reg_addr(ra), .i_reg_wdata(wd),
        .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rgd), .o_rd_data(rdat), .o_rd_valid(rval),
        .o_cpu_stall(stall), .o_irq_suppress(irq), .o_flash_prog(prog), .o_flash_erase(ers),
        .o_flash_addr(fa), .o_region_busy_flag(busy));
    // ****************************************
    // Access tasks
    // ****************************************
    function automatic logic [15:0] fd(input logic [14:0] a);
        return {1'b0, a} ^ 16'h5a5a;
    endfunction : fd
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task automatic sp(input logic [2:0] c, input logic [14:0] a, input logic [3:0] l);
        @(posedge clk);
        sp_req <= 1'b1;
        cmd <= c;
        sp_a <= a;
        lk <= l;
        wt(1);
        sp_req <= 1'b0;
    endtask : sp
    task automatic rd(input logic [14:0] a, input logic l, input logic [15:0] e);
        @(posedge clk);
        rd_req <= 1'b1;
        rd_a <= a;
        ld <= l;
        wt(1);
        rd_req <= 1'b0;
        `CHK({rval, rdat}, {1'b1, e})
    endtask : rd
    task automatic rg(input logic w, input logic [3:0] a, input logic [15:0] d,
        input logic [15:0] e);
        @(posedge clk);
        rwr <= w;
        rrd <= !w;
        ra <= a;
        wd <= d;
        wt(1);
        rwr <= 1'b0;
        rrd <= 1'b0;
        if (!w) `CHK(rgd, e)
    endtask : rg
    task automatic setpc(input logic [14:0] p);
        @(posedge clk);
        pc <= p;
    endtask : setpc
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        wt(1);
        `CHK(rdat, `FPG_RD_BLOCKED)
        rg(0, `FPG_REG_LOCK, 16'h0, 16'h000f);
        rg(0, 4'hf, 16'h0, 16'h0);
        $display("test reset done");
        sp(`FPG_CMD_WRITE, 15'h0100, 4'hf);
        `CHK({prog, busy, stall, fa}, {3'b110, 15'h0100})
        rd(15'h0100, 0, `FPG_RD_BLOCKED);
        rd(15'h7100, 0, fd(15'h7100));
        rg(0, `FPG_REG_STAT, 16'h0, 16'h0003);
        wt(`FPG_OP_CYC + 4);
        rd(15'h0100, 1, `FPG_RD_BLOCKED);
        sp(`FPG_CMD_REEN, 15'h0, 4'hf);
        `CHK(busy, 1'b0)
        rd(15'h0100, 0, fd(15'h0100));
        $display("test concurrent write done");
        sp(`FPG_CMD_ERASE, 15'h7200, 4'hf);
        wt(1);
        `CHK({stall, busy, fa}, {2'b10, 15'h7200})
        wt(`FPG_OP_CYC + 4);
        `CHK(stall, 1'b0)
        setpc(15'h0100);
        sp(`FPG_CMD_WRITE, 15'h0200, 4'hf);
        `CHK({prog, busy}, 2'b00)
        setpc(15'h7800);
        sp(`FPG_CMD_ERASE, 15'h0200, 4'hf);
        wt(`FPG_OP_CYC + 4);
        sp(`FPG_CMD_LOAD, 15'h0200, 4'hf);
        `CHK(busy, 1'b0)
        $display("test stall and origin done");
        sp(`FPG_CMD_LOCKSET, 15'h0, 4'b1110);
        sp(`FPG_CMD_WRITE, 15'h0300, 4'hf);
        `CHK(prog, 1'b0)
        rd(15'h0300, 1, fd(15'h0300));
        sp(`FPG_CMD_LOCKSET, 15'h0, 4'b1101);
        rg(0, `FPG_REG_LOCK, 16'h0, 16'h000c);
        rd(15'h0300, 1, `FPG_RD_BLOCKED);
        rg(1, `FPG_REG_CTRL, 16'h9000, 16'h0);
        setpc(15'h0100);
        wt(2);
        `CHK(irq, 1'b1)
        sp(`FPG_CMD_CHIPERASE, 15'h0, 4'hf);
        wt(`FPG_OP_CYC + 4);
        rg(0, `FPG_REG_LOCK, 16'h0, 16'h000f);
        `CHK(irq, 1'b0)
        setpc(15'h7800);
        sp(`FPG_CMD_LOCKSET, 15'h0, 4'b0111);
        rg(1, `FPG_REG_CTRL, 16'h1000, 16'h0);
        wt(2);
        `CHK(irq, 1'b1)
        sp(`FPG_CMD_WRITE, 15'h7300, 4'hf);
        `CHK(prog, 1'b1)
        wt(`FPG_OP_CYC + 4);
        setpc(15'h0100);
        rd(15'h7300, 1, `FPG_RD_BLOCKED);
        rd(15'h7300, 0, fd(15'h7300));
        $display("test lock modes done");
        setpc(15'h7800);
        sp(`FPG_CMD_CHIPERASE, 15'h0, 4'hf);
        sp(`FPG_CMD_LOCKSET, 15'h0, 4'b1001);
        sp(`FPG_CMD_WRITE, 15'h7300, 4'hf);
        `CHK(prog, 1'b0)
        sp(`FPG_CMD_WRITE, 15'h0300, 4'hf);
        `CHK({prog, busy}, 2'b11)
        wt(`FPG_OP_CYC + 4);
        sp(`FPG_CMD_REEN, 15'h0, 4'hf);
        rd(15'h0300, 1, `FPG_RD_BLOCKED);
        rd(15'h7300, 1, fd(15'h7300));
        sp(`FPG_CMD_LOCKSET, 15'h0, 4'b0011);
        sp(`FPG_CMD_WRITE, 15'h7300, 4'hf);
        `CHK(prog, 1'b0)
        setpc(15'h0100);
        rd(15'h7300, 1, `FPG_RD_BLOCKED);
        $display("test remaining lock modes done");
        give_verdict();
    end
endmodule : fpg_guard_tb_top
